// ### rtl/wocp_config_port.sv
`timescale 1ns/100ps
// Contract
// [R01] serial port works only in extended mode
// [R02] bits taken only while select low
// [R03] data sampled on serial clock rise
// [R04] frame is exactly 32 bits, msb first
// [R05] header is eleven zeros then a one
// [R06] four address bits then sixteen value bits
// [R07] next frame starts at 33rd clock
// [R08] registers are write only, no readback
// [R09] host writes all registers first time
// [R10] normal mode uses pins, not registers
// [R11] host avoids writes during calibration
// [R12] host sets config bit 15, 7:0
// [R13] bit 14 selects differential resync input
// [R14] bit 13 skips termination trim
// [R15] bit 12 enables duty-cycle stabilizer
// [R16] bit 11 sets double-rate clock phase
// [R17] bit 10 selects single-rate output
// [R18] bit 9 selects output swing
// [R19] bit 8 selects single-rate data edge
// [R20] host writes bit 8 zero in double-rate
// [R21] registers take power-on defaults at reset
// [R22] short or bad-header frames are dropped
// [R23] write after last bit; reserved ignored
module wocp_config_port (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic EXT_CTRL_EN,
	input wire logic SERIAL_CLOCK,
	input wire logic SERIAL_WRITE_DATA,
	input wire logic SERIAL_PORT_SELECT_N,
	input wire logic EDGE_SELECT_PIN,
	input wire logic SWING_SELECT_PIN,
	input wire logic DDR_SELECT_PIN,
	output wocp_pkg::wocp_ctrl_t CTRL,
	output logic FRAME_ACCEPTED,
	output logic FRAME_REJECTED
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// true for the six implemented addresses
	function automatic logic addr_is_mapped(input logic [3:0] a);
		addr_is_mapped = (a == wocp_pkg::ADDR_CONFIG) || (a == wocp_pkg::ADDR_OFFSET) ||
			(a == wocp_pkg::ADDR_FULL_SCALE) || (a == wocp_pkg::ADDR_PHASE_FINE) ||
			(a == wocp_pkg::ADDR_PHASE_COARSE) || (a == wocp_pkg::ADDR_TEST_PATTERN);
	endfunction : addr_is_mapped

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	logic [6:0] pins_s;
	logic ext_mode;
	logic sclk_s;
	logic serial_write_data_s;
	logic sel_n_s;
	logic edge_pin_s;
	logic swing_pin_s;
	logic ddr_pin_s;

	wocp_sync2 #(
		.WIDTH(wocp_pkg::SYNC_WIDTH),
		.RESET_VALUE(wocp_pkg::SYNC_RESET)
	) u_sync (
		.CLK(CLK),
		.RST_B(RST_B),
		.CE(CE),
		.D({EXT_CTRL_EN, SERIAL_CLOCK, SERIAL_WRITE_DATA, SERIAL_PORT_SELECT_N,
			EDGE_SELECT_PIN, SWING_SELECT_PIN, DDR_SELECT_PIN}),
		.Q(pins_s)
	);

	assign {ext_mode, sclk_s, serial_write_data_s, sel_n_s, edge_pin_s, swing_pin_s, ddr_pin_s} = pins_s;

	// ----------------------------------------
	// serial clock edge detection
	// ----------------------------------------
	logic sclk_prev;
	logic next_sclk_prev;
	logic sclk_rise;

	always_comb begin
		next_sclk_prev = CE ? sclk_s : sclk_prev;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= next_sclk_prev;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_prev; // R03

	// ----------------------------------------
	// frame receiver
	// ----------------------------------------
	wocp_pkg::wocp_frame_t frame;
	logic frame_done;
	logic clk_w;

	assign clk_w = CLK; // receiver runs on the system clock

	wocp_frame_rx u_rx (
		.clk(clk_w),
		.rst_b(RST_B),
		.ce(CE),
		.enable(ext_mode),
		.sclk_rise(sclk_rise),
		.serial_write_data(serial_write_data_s),
		.sel_n(sel_n_s),
		.frame(frame),
		.done(frame_done)
	);

	// ----------------------------------------
	// frame check
	// ----------------------------------------
	logic header_ok;
	logic write_ok;

	assign header_ok = frame.header == wocp_pkg::FRAME_HEADER; // R05
	assign write_ok = CE && frame_done && header_ok && ext_mode; // R01 R22 R23

	// ----------------------------------------
	// write-only register bank
	// ----------------------------------------
	logic [15:0] cfg_reg;
	logic [15:0] ofs_reg;
	logic [15:0] fs_reg;
	logic [15:0] fine_reg;
	logic [15:0] coarse_reg;
	logic [15:0] tp_reg;
	logic [15:0] next_cfg_reg;
	logic [15:0] next_ofs_reg;
	logic [15:0] next_fs_reg;
	logic [15:0] next_fine_reg;
	logic [15:0] next_coarse_reg;
	logic [15:0] next_tp_reg;

	// addressed register takes the value; there is no read path
	always_comb begin
		next_cfg_reg = cfg_reg;
		next_ofs_reg = ofs_reg;
		next_fs_reg = fs_reg;
		next_fine_reg = fine_reg;
		next_coarse_reg = coarse_reg;
		next_tp_reg = tp_reg;
		if (write_ok) begin // R08 R23
			unique case (frame.addr) // R06
				wocp_pkg::ADDR_CONFIG: next_cfg_reg = frame.value;
				wocp_pkg::ADDR_OFFSET: next_ofs_reg = frame.value;
				wocp_pkg::ADDR_FULL_SCALE: next_fs_reg = frame.value;
				wocp_pkg::ADDR_PHASE_FINE: next_fine_reg = frame.value;
				wocp_pkg::ADDR_PHASE_COARSE: next_coarse_reg = frame.value;
				wocp_pkg::ADDR_TEST_PATTERN: next_tp_reg = frame.value;
				default: next_tp_reg = tp_reg; // reserved addresses
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cfg_reg <= wocp_pkg::CONFIG_RESET; // R21
			ofs_reg <= wocp_pkg::OFFSET_RESET;
			fs_reg <= wocp_pkg::FULL_SCALE_RESET;
			fine_reg <= wocp_pkg::PHASE_FINE_RESET;
			coarse_reg <= wocp_pkg::PHASE_COARSE_RESET;
			tp_reg <= wocp_pkg::TEST_PATTERN_RESET;
		end else begin
			cfg_reg <= next_cfg_reg;
			ofs_reg <= next_ofs_reg;
			fs_reg <= next_fs_reg;
			fine_reg <= next_fine_reg;
			coarse_reg <= next_coarse_reg;
			tp_reg <= next_tp_reg;
		end
	end

	// ----------------------------------------
	// effective settings
	// ----------------------------------------
	wocp_pkg::wocp_ctrl_t next_ctrl;
	logic next_accepted;
	logic next_rejected;

	// extended mode follows registers, normal mode follows the rate, swing and edge pins with all other settings fixed
	always_comb begin
		next_ctrl = CTRL;
		next_accepted = FRAME_ACCEPTED;
		next_rejected = FRAME_REJECTED;
		if (CE) begin
			next_accepted = write_ok && addr_is_mapped(frame.addr);
			next_rejected = frame_done && !(header_ok && addr_is_mapped(frame.addr));
			next_ctrl.offset_adjust = wocp_pkg::OFFSET_RESET;
			next_ctrl.full_scale_adjust = wocp_pkg::FULL_SCALE_RESET;
			next_ctrl.phase_fine = wocp_pkg::PHASE_FINE_RESET;
			next_ctrl.phase_coarse = wocp_pkg::PHASE_COARSE_RESET;
			next_ctrl.test_pattern = wocp_pkg::TEST_PATTERN_RESET;
			if (ext_mode) begin
				next_ctrl.diff_clock_reset_sel = cfg_reg[wocp_pkg::CFG_DIFF_RESET_BIT]; // R13
				next_ctrl.termination_trim_skip = cfg_reg[wocp_pkg::CFG_TRIM_SKIP_BIT]; // R14
				next_ctrl.duty_cycle_stabilizer_en = cfg_reg[wocp_pkg::CFG_DCS_BIT]; // R15
				next_ctrl.single_rate_select = cfg_reg[wocp_pkg::CFG_SINGLE_RATE_BIT]; // R17
				next_ctrl.double_rate_clock_phase = cfg_reg[wocp_pkg::CFG_DDR_PHASE_BIT] &
					~cfg_reg[wocp_pkg::CFG_SINGLE_RATE_BIT]; // R16
				next_ctrl.output_swing_select = cfg_reg[wocp_pkg::CFG_SWING_BIT]; // R18
				next_ctrl.edge_select = cfg_reg[wocp_pkg::CFG_EDGE_BIT] &
					cfg_reg[wocp_pkg::CFG_SINGLE_RATE_BIT]; // R19
				next_ctrl.offset_adjust = ofs_reg;
				next_ctrl.full_scale_adjust = fs_reg;
				next_ctrl.phase_fine = fine_reg;
				next_ctrl.phase_coarse = coarse_reg;
				next_ctrl.test_pattern = tp_reg;
			end else begin
				next_ctrl.diff_clock_reset_sel = 1'b0; // R10
				next_ctrl.termination_trim_skip = 1'b0;
				next_ctrl.duty_cycle_stabilizer_en = 1'b1;
				next_ctrl.single_rate_select = ~ddr_pin_s;
				next_ctrl.double_rate_clock_phase = 1'b0;
				next_ctrl.output_swing_select = swing_pin_s;
				next_ctrl.edge_select = edge_pin_s & ~ddr_pin_s;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			CTRL <= '0;
			FRAME_ACCEPTED <= 1'b0;
			FRAME_REJECTED <= 1'b0;
		end else begin
			CTRL <= next_ctrl;
			FRAME_ACCEPTED <= next_accepted;
			FRAME_REJECTED <= next_rejected;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);

	logic first_cycle;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			first_cycle <= 1'b1;
		end else begin
			first_cycle <= 1'b0;
		end
	end

	property p_por_values;
		first_cycle |-> cfg_reg == 16'h92ff && fs_reg == 16'h807f && tp_reg == 16'hf7ff;
	endproperty
	a_por_values: assert property (p_por_values) else $error("wrong power-on value"); // R21

	property p_normal_ignored;
		!ext_mode |=> !frame_done && $stable(cfg_reg) && $stable(ofs_reg) && $stable(tp_reg);
	endproperty
	a_normal_ignored: assert property (p_normal_ignored) else $error("write taken in normal mode"); // R01

	property p_bad_header;
		frame_done && !header_ok |=> $stable(cfg_reg) && $stable(ofs_reg) && $stable(tp_reg);
	endproperty
	a_bad_header: assert property (p_bad_header) else $error("bad header updated a register"); // R22

	property p_cfg_write;
		write_ok && frame.addr == 4'h1 |=> cfg_reg == $past(frame.value) ##1 CTRL.single_rate_select ==
			cfg_reg[10];
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write not applied"); // R23

	property p_reserved;
		write_ok && !addr_is_mapped(frame.addr) |=> $stable(cfg_reg) && $stable(fs_reg) && $stable(coarse_reg);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved write had an effect"); // R23

	property p_normal_pins;
		CE && !ext_mode |=> CTRL.output_swing_select == $past(swing_pin_s) && CTRL.duty_cycle_stabilizer_en;
	endproperty
	a_normal_pins: assert property (p_normal_pins) else $error("normal mode not following pins"); // R10

	property p_diff_reset;
		CE && ext_mode |=> CTRL.diff_clock_reset_sel == $past(cfg_reg[14]);
	endproperty
	a_diff_reset: assert property (p_diff_reset) else $error("resync input select wrong"); // R13

	property p_dcs;
		CE && ext_mode |=> CTRL.duty_cycle_stabilizer_en == $past(cfg_reg[12]);
	endproperty
	a_dcs: assert property (p_dcs) else $error("stabilizer enable wrong"); // R15

	property p_ddr_phase;
		CE && ext_mode |=> CTRL.double_rate_clock_phase == ($past(cfg_reg[11]) && !$past(cfg_reg[10]));
	endproperty
	a_ddr_phase: assert property (p_ddr_phase) else $error("double-rate phase wrong"); // R16

	property p_sdr_edge;
		CE && ext_mode && cfg_reg[10] |=> CTRL.edge_select == $past(cfg_reg[8]);
	endproperty
	a_sdr_edge: assert property (p_sdr_edge) else $error("single-rate edge wrong"); // R19

endmodule : wocp_config_port

// ### rtl/wocp_pkg.sv
package wocp_pkg;

	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 32;
	localparam logic [4:0] LAST_BIT_INDEX = 5'h1f;
	localparam logic [11:0] FRAME_HEADER = 12'h001;

	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [3:0] ADDR_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_OFFSET = 4'h2;
	localparam logic [3:0] ADDR_FULL_SCALE = 4'h3;
	localparam logic [3:0] ADDR_PHASE_FINE = 4'hd;
	localparam logic [3:0] ADDR_PHASE_COARSE = 4'he;
	localparam logic [3:0] ADDR_TEST_PATTERN = 4'hf;

	// ----------------------------------------
	// values after power-on reset
	// ----------------------------------------
	localparam logic [15:0] CONFIG_RESET = 16'h92ff;
	localparam logic [15:0] OFFSET_RESET = 16'h007f;
	localparam logic [15:0] FULL_SCALE_RESET = 16'h807f;
	localparam logic [15:0] PHASE_FINE_RESET = 16'h007f;
	localparam logic [15:0] PHASE_COARSE_RESET = 16'h03ff;
	localparam logic [15:0] TEST_PATTERN_RESET = 16'hf7ff;

	// ----------------------------------------
	// configuration register bit positions
	// ----------------------------------------
	localparam int CFG_DIFF_RESET_BIT = 14;
	localparam int CFG_TRIM_SKIP_BIT = 13;
	localparam int CFG_DCS_BIT = 12;
	localparam int CFG_DDR_PHASE_BIT = 11;
	localparam int CFG_SINGLE_RATE_BIT = 10;
	localparam int CFG_SWING_BIT = 9;
	localparam int CFG_EDGE_BIT = 8;

	// ----------------------------------------
	// pin synchroniser order and reset levels
	// {ext_ctrl, sclk, serial_write_data, select_n, edge, swing, ddr}
	// ----------------------------------------
	localparam int SYNC_WIDTH = 7;
	localparam logic [6:0] SYNC_RESET = 7'h08;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [11:0] header;
		logic [3:0] addr;
		logic [15:0] value;
	} wocp_frame_t;

	typedef struct packed {
		logic diff_clock_reset_sel;
		logic termination_trim_skip;
		logic duty_cycle_stabilizer_en;
		logic double_rate_clock_phase;
		logic single_rate_select;
		logic output_swing_select;
		logic edge_select;
		logic [15:0] offset_adjust;
		logic [15:0] full_scale_adjust;
		logic [15:0] phase_fine;
		logic [15:0] phase_coarse;
		logic [15:0] test_pattern;
	} wocp_ctrl_t;

endpackage : wocp_pkg

// ### rtl/wocp_sync2.sv
`timescale 1ns/100ps
// two-stage synchroniser for pins from outside the clock domain
module wocp_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic [WIDTH-1:0] D,
	output logic [WIDTH-1:0] Q
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	// first stage feeds only the second stage
	always_comb begin
		next_meta = CE ? D : meta;
		next_q = CE ? meta : Q;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			meta <= RESET_VALUE;
			Q <= RESET_VALUE;
		end else begin
			meta <= next_meta;
			Q <= next_q;
		end
	end

endmodule : wocp_sync2

// ### rtl/wocp_frame_rx.sv
`timescale 1ns/100ps
// shifts serial bits into 32-bit frames, msb first
module wocp_frame_rx (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic enable,
	input wire logic sclk_rise,
	input wire logic serial_write_data,
	input wire logic sel_n,
	output wocp_pkg::wocp_frame_t frame,
	output logic done
);

	logic [31:0] shift;
	logic [31:0] next_shift;
	logic [4:0] count;
	logic [4:0] next_count;
	wocp_pkg::wocp_frame_t next_frame;
	logic next_done;

	// bit counter, shifter and frame capture
	always_comb begin
		next_shift = shift;
		next_count = count;
		next_frame = frame;
		next_done = done;
		if (ce) begin
			next_done = 1'b0;
			if (!enable || sel_n) begin
				next_count = 5'h00; // R01 R02 R22
			end else if (sclk_rise) begin
				next_shift = {shift[30:0], serial_write_data}; // R03 R04
				next_count = count + 5'h01;
				if (count == wocp_pkg::LAST_BIT_INDEX) begin
					next_frame = {shift[30:0], serial_write_data}; // R05 R06
					next_done = 1'b1;
					next_count = 5'h00; // R07
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			shift <= 32'h0000_0000;
			count <= 5'h00;
			frame <= '0;
			done <= 1'b0;
		end else begin
			shift <= next_shift;
			count <= next_count;
			frame <= next_frame;
			done <= next_done;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_last_bit;
		ce && enable && !sel_n && sclk_rise && count == 5'h1f;
	endsequence

	property p_frame_end;
		@(posedge clk) disable iff (!rst_b)
		s_last_bit |=> done && count == 5'h00;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame not closed at 32nd bit"); // R07

	property p_only_on_last;
		@(posedge clk) disable iff (!rst_b)
		$rose(done) |-> $past(count) == 5'h1f && $past(sclk_rise);
	endproperty
	a_only_on_last: assert property (p_only_on_last) else $error("frame closed early"); // R04

	property p_select_high;
		@(posedge clk) disable iff (!rst_b)
		ce && sel_n |=> count == 5'h00 && !done;
	endproperty
	a_select_high: assert property (p_select_high) else $error("bits kept with select high"); // R02

	property p_count_step;
		@(posedge clk) disable iff (!rst_b)
		ce && enable && !sel_n && sclk_rise && count != 5'h1f |=> count == $past(count) + 5'h01;
	endproperty
	a_count_step: assert property (p_count_step) else $error("rising edge not counted"); // R03

endmodule : wocp_frame_rx

// ### bench/wocp_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// serial host: drives clock, data and select
// ----------------------------------------
module wocp_host_model (
	output logic SERIAL_CLOCK,
	output logic SERIAL_WRITE_DATA,
	output logic SERIAL_PORT_SELECT_N
);
	int half_ns = 32;

	// idle: clock parked low, select high
	initial begin
		SERIAL_CLOCK = 1'b0;
		SERIAL_WRITE_DATA = 1'b0;
		SERIAL_PORT_SELECT_N = 1'b1;
	end

	// shifts nbits of a frame msb first, data set up a half period before each rise
	// no calibration runs in this bench, so writes never overlap one
	task automatic send(input wocp_pkg::wocp_frame_t f, input int nbits, input bit hold_sel);
		for (int i = 0; i < nbits; i++) begin
			SERIAL_PORT_SELECT_N <= 1'b0;
			SERIAL_WRITE_DATA <= f[31-i];
			#(half_ns);
			SERIAL_CLOCK <= 1'b1;
			#(half_ns);
			SERIAL_CLOCK <= 1'b0;
		end
		// released data line shows the inverse, never the last bit
		if (!hold_sel) begin
			SERIAL_PORT_SELECT_N <= 1'b1;
			SERIAL_WRITE_DATA <= ~SERIAL_WRITE_DATA;
		end
	endtask : send
endmodule : wocp_host_model

// ### bench/tb.sv
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic ext = 1'b1;
	logic edge_pin = 1'b0;
	logic swing_pin = 1'b1;
	logic ddr_pin = 1'b1;
	logic sclk;
	logic serial_write_data;
	logic sel_n;
	logic acc;
	logic rej;
	wocp_pkg::wocp_ctrl_t ctrl;
	logic [15:0] regs [16];
	int n_mismatch = 0;
	int checks = 0;
	int n_acc = 0;
	int n_rej = 0;
	int exp_acc = 0;
	int exp_rej = 0;
	int cyc = 0;
	logic [15:0] v;

	// ----------------------------------------
	// clock, design and host
	// ----------------------------------------
	always #4 clk = ~clk;

	wocp_config_port u_dut (
		.CLK(clk),
		.RST_B(rst_b),
		.CE(ce),
		.EXT_CTRL_EN(ext),
		.SERIAL_CLOCK(sclk),
		.SERIAL_WRITE_DATA(serial_write_data),
		.SERIAL_PORT_SELECT_N(sel_n),
		.EDGE_SELECT_PIN(edge_pin),
		.SWING_SELECT_PIN(swing_pin),
		.DDR_SELECT_PIN(ddr_pin),
		.CTRL(ctrl),
		.FRAME_ACCEPTED(acc),
		.FRAME_REJECTED(rej)
	);

	wocp_host_model u_host (
		.SERIAL_CLOCK(sclk),
		.SERIAL_WRITE_DATA(serial_write_data),
		.SERIAL_PORT_SELECT_N(sel_n)
	);

	// counts result pulses and cuts a hang short
	always @(posedge clk) begin
		if (acc === 1'b1) n_acc++;
		if (rej === 1'b1) n_rej++;
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			summarize();
		end
	end

	// ----------------------------------------
	// comparison, expectation and reporting
	// ----------------------------------------
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	// power-on values of the register model
	task automatic por_regs();
		foreach (regs[i]) regs[i] = 16'h0000;
		regs[1] = wocp_pkg::CONFIG_RESET;
		regs[2] = wocp_pkg::OFFSET_RESET;
		regs[3] = wocp_pkg::FULL_SCALE_RESET;
		regs[13] = wocp_pkg::PHASE_FINE_RESET;
		regs[14] = wocp_pkg::PHASE_COARSE_RESET;
		regs[15] = wocp_pkg::TEST_PATTERN_RESET;
	endtask : por_regs

	// settings expected in extended mode
	function automatic wocp_pkg::wocp_ctrl_t exp_ctrl();
		wocp_pkg::wocp_ctrl_t c;
		logic [15:0] g;
		g = regs[1];
		c.diff_clock_reset_sel = g[14];
		c.termination_trim_skip = g[13];
		c.duty_cycle_stabilizer_en = g[12];
		c.double_rate_clock_phase = g[11] & ~g[10];
		c.single_rate_select = g[10];
		c.output_swing_select = g[9];
		c.edge_select = g[8] & g[10];
		c.offset_adjust = regs[2];
		c.full_scale_adjust = regs[3];
		c.phase_fine = regs[13];
		c.phase_coarse = regs[14];
		c.test_pattern = regs[15];
		return c;
	endfunction : exp_ctrl

	// one access, then settle and compare settings and pulse counts
	task automatic xfer(input logic [11:0] hdr, input logic [3:0] a, input logic [15:0] val, input int nb,
		input bit hold);
		wocp_pkg::wocp_frame_t f;
		f.header = hdr;
		f.addr = a;
		f.value = val;
		u_host.send(f, nb, hold);
		if (nb == 32 && ext === 1'b1 && ce === 1'b1) begin
			if (hdr === wocp_pkg::FRAME_HEADER && a inside {4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf}) begin
				regs[a] = val;
				exp_acc++;
			end else
				exp_rej++;
		end
		repeat (10) @(posedge clk);
		if (ext === 1'b1) check("settings", 128'(ctrl), 128'(exp_ctrl()));
		check("accepted", 128'(n_acc), 128'(exp_acc));
		check("rejected", 128'(n_rej), 128'(exp_rej));
	endtask : xfer

	task automatic done_test(input string name);
		$display("test %s done", name);
	endtask : done_test

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'hdfb0cb03));
		por_regs();
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		check("por settings", 128'(ctrl), 128'(exp_ctrl()));
		done_test("reset");
		// first use writes every register, select held low throughout
		xfer(12'h001, 4'h1, 16'h92ff, 32, 1'b1);
		xfer(12'h001, 4'h2, 16'($urandom), 32, 1'b1);
		xfer(12'h001, 4'h3, 16'($urandom), 32, 1'b1);
		xfer(12'h001, 4'hd, 16'($urandom), 32, 1'b1);
		xfer(12'h001, 4'he, 16'($urandom), 32, 1'b1);
		xfer(12'h001, 4'hf, 16'($urandom), 32, 1'b0);
		done_test("initial write");
		// walking one over each control bit, single-rate when edge bit set
		for (int i = 8; i < 15; i++) begin
			v = 16'h80ff | (16'h0001 << i);
			if (i == 8) v[10] = 1'b1;
			xfer(12'h001, 4'h1, v, 32, 1'b0);
		end
		for (int i = 0; i < 8; i++) begin
			v = 16'($urandom) | 16'h80ff;
			if (v[10] == 1'b0) v[8] = 1'b0;
			xfer(12'h001, 4'h1, v, 32, 1'b0);
		end
		done_test("config bits");
		// bad headers, reserved addresses, short frames
		xfer(12'h003, 4'h1, 16'h80ff, 32, 1'b0);
		xfer(12'h000, 4'h2, 16'h1234, 32, 1'b0);
		foreach (regs[i]) begin
			if (!(i inside {1, 2, 3, 13, 14, 15})) begin
				xfer(12'h001, 4'(i), 16'($urandom), 32, 1'b1);
			end
		end
		xfer(12'h001, 4'h2, 16'h5aa5, 20, 1'b0);
		xfer(12'h001, 4'h2, 16'hc3c3, 31, 1'b0);
		xfer(12'h001, 4'h2, 16'h0f0f, 32, 1'b0);
		done_test("refused frames");
		// very slow serial clock is still taken
		u_host.half_ns = 400;
		xfer(12'h001, 4'he, 16'($urandom), 32, 1'b0);
		u_host.half_ns = 32;
		done_test("slow clock");
		// clock enable low freezes the port, so a whole frame is lost
		@(posedge clk);
		ce <= 1'b0;
		xfer(12'h001, 4'hf, 16'($urandom), 32, 1'b0);
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		done_test("clock enable");
		// normal mode: pins rule, serial port ignored
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			ext <= 1'b0;
			edge_pin <= 1'($urandom);
			swing_pin <= 1'($urandom);
			ddr_pin <= 1'(i);
			repeat (10) @(posedge clk);
			check("pin settings", 128'({ctrl.single_rate_select, ctrl.output_swing_select, ctrl.edge_select,
				ctrl.offset_adjust, ctrl.test_pattern}), 128'({~ddr_pin, swing_pin, edge_pin & ~ddr_pin,
				wocp_pkg::OFFSET_RESET, wocp_pkg::TEST_PATTERN_RESET}));
			xfer(12'h001, 4'h2, 16'($urandom), 32, 1'b0);
		end
		@(posedge clk);
		ext <= 1'b1;
		repeat (10) @(posedge clk);
		check("settings kept", 128'(ctrl), 128'(exp_ctrl()));
		done_test("normal mode");
		// second reset restores power-on values
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		por_regs();
		repeat (6) @(posedge clk);
		check("reset again", 128'(ctrl), 128'(exp_ctrl()));
		done_test("second reset");
		summarize();
	end
endmodule : tb
